// ### design/pclk_divider.sv
// Purpose: peripheral clock enable divider, full, half or quarter rate
// Assumes: ratio comes from a register on the same clock
// Notes: a new ratio is taken only at the end of a whole period
`timescale 1ns/1ps
module pclk_divider
  import pwr_clk_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // control
  input wire logic run,
  input wire logic [1:0] ratio,
  // enable pulse out
  output logic pclk_en
);

  logic [1:0] cnt_reg;
  logic [1:0] cnt_next;
  logic [1:0] act_reg;
  logic [1:0] act_next;
  logic en_reg;
  logic en_next;
  logic [1:0] last;

  // ***************************************************
  // divide state
  // ***************************************************
  // terminal count of the ratio in use
  always_comb
  begin
    unique case (act_reg)
      DIV_FULL: last = 2'h0;
      DIV_HALF: last = 2'h1;
      default: last = 2'h3;
    endcase
  end

  // ratio swaps only at wrap, so no period is cut short
  always_comb
  begin
    cnt_next = cnt_reg;
    act_next = act_reg;
    en_next = 1'b0;
    if (run)
    begin
      if (cnt_reg >= last)
      begin
        cnt_next = 2'h0;
        en_next = 1'b1;
        act_next = ratio;
      end
      else
      begin
        cnt_next = cnt_reg + 2'h1;
      end
    end
  end

  // registers; quarter rate out of reset
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_reg <= 2'h0;
      act_reg <= DIV_RESET;
      en_reg <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      act_reg <= act_next;
      en_reg <= en_next;
    end
  end

  assign pclk_en = en_reg;

endmodule

// ### design/pwr_clk_ctrl.sv
// Purpose: power mode controller and peripheral clock control
// Assumes: APB master on sys_clk; irq_pending is on sys_clk
// Notes: wake_irq and pll_lock are asynchronous and are synchronised
// Behaviour
// - idle halts the processor clock until reset or an interrupt
// - peripheral clock enables keep running while idle
// - idle gates processor, memory, controller and bus clocks; here only cpu_clk_en and bus_clk_en are gated
// - power-down stops the oscillator and every internal clock
// - power-down keeps all state and freezes output pins
// - power-down ends on reset or an asynchronous wake interrupt
// - rtc clock is peripheral clock or external 32 kHz, runs in power-down
// - each peripheral has its own clock enable bit
// - peripheral clock is cpu clock divided by one, two or four
// - divider runs at quarter rate after reset
// - pll stays enabled through idle if it was running
// - wake from power-down waits out the wake-up timer
// - pll is off and bypassed after reset
//
// The implementer's own choices: register access over APB and the register offsets.
`timescale 1ns/1ps
module pwr_clk_ctrl
  import pwr_clk_pkg::*;
#(
  parameter int N_PERIPH = N_PERIPH_DEF,
  parameter int WAKE_CYCLES = WAKE_CYCLES_DEF
)
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // apb slave
  input wire apb_req_t apb_req,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // wake sources
  input wire logic irq_pending,
  input wire logic wake_irq,
  input wire logic pll_lock,
  // clock gates and holds
  output gate_t gate,
  output logic pclk_en,
  output logic [N_PERIPH-1:0] periph_clk_en,
  output logic rtc_ext_sel,
  output logic rtc_pclk_en
);

  localparam int WCW = $clog2(WAKE_CYCLES + 1);
  localparam logic [WCW-1:0] WAKE_LOAD = WCW'(WAKE_CYCLES);

  // ***************************************************
  // synchronisers
  // ***************************************************
  logic [1:0] sync1_reg;
  logic [1:0] sync2_reg;
  logic wake_s;
  logic lock_s;

  // first stage feeds only the second stage
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1_reg <= 2'h0;
      sync2_reg <= 2'h0;
    end
    else
    begin
      sync1_reg <= {pll_lock, wake_irq};
      sync2_reg <= sync1_reg;
    end
  end

  assign wake_s = sync2_reg[0];
  assign lock_s = sync2_reg[1];

  // ***************************************************
  // apb decode
  // ***************************************************
  logic setup;
  logic wr;
  logic mapped;

  assign setup = apb_req.psel && !apb_req.penable;
  assign wr = apb_req.psel && apb_req.penable && apb_req.pwrite;

  // unmapped words answer with an error
  always_comb
  begin
    mapped = addr_is(apb_req.paddr, OFS_MODE)
      || addr_is(apb_req.paddr, OFS_PERIPH)
      || addr_is(apb_req.paddr, OFS_DIV)
      || addr_is(apb_req.paddr, OFS_CLK)
      || addr_is(apb_req.paddr, OFS_STAT);
  end

  // zero wait states
  assign pready = 1'b1;
  assign pslverr = apb_req.psel && apb_req.penable && !mapped;

  // ***************************************************
  // software registers
  // ***************************************************
  logic [1:0] mode_reg;
  logic [1:0] mode_next;
  logic [N_PERIPH-1:0] periph_reg;
  logic [N_PERIPH-1:0] periph_next;
  logic [1:0] div_reg;
  logic [1:0] div_next;
  logic [2:0] clk_reg;
  logic [2:0] clk_next;
  logic mode_clr;

  // hardware clears the mode request on wake; a write in the
  // same cycle lands after the clear, so it is not lost
  always_comb
  begin
    mode_next = mode_reg;
    periph_next = periph_reg;
    div_next = div_reg;
    clk_next = clk_reg;
    if (mode_clr)
    begin
      mode_next = MODE_RESET;
    end
    if (wr && addr_is(apb_req.paddr, OFS_MODE))
    begin
      mode_next = apb_req.pwdata[1:0];
    end
    if (wr && addr_is(apb_req.paddr, OFS_PERIPH))
    begin
      periph_next = apb_req.pwdata[N_PERIPH-1:0];
    end
    if (wr && addr_is(apb_req.paddr, OFS_DIV))
    begin
      div_next = apb_req.pwdata[1:0];
    end
    if (wr && addr_is(apb_req.paddr, OFS_CLK))
    begin
      clk_next = apb_req.pwdata[2:0];
    end
  end

  // nothing here is touched by power-down, so contents survive it
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode_reg <= MODE_RESET;
      periph_reg <= '1;
      div_reg <= DIV_RESET;
      clk_reg <= CLK_RESET;
    end
    else
    begin
      mode_reg <= mode_next;
      periph_reg <= periph_next;
      div_reg <= div_next;
      clk_reg <= clk_next;
    end
  end

  // ***************************************************
  // power mode state machine
  // ***************************************************
  pm_state_t st_reg;
  pm_state_t st_next;
  logic [WCW-1:0] wcnt_reg;
  logic [WCW-1:0] wcnt_next;

  // power-down wins if both mode bits are set
  always_comb
  begin
    st_next = st_reg;
    wcnt_next = wcnt_reg;
    mode_clr = 1'b0;
    unique case (st_reg)
      ST_RUN:
      begin
        if (mode_reg[MODE_PDOWN_BIT])
        begin
          st_next = ST_PDOWN;
        end
        else if (mode_reg[MODE_IDLE_BIT])
        begin
          st_next = ST_IDLE;
        end
      end
      ST_IDLE:
      begin
        // only an interrupt gets the cpu back
        if (irq_pending)
        begin
          st_next = ST_RUN;
          mode_clr = 1'b1;
        end
      end
      ST_PDOWN:
      begin
        if (wake_s)
        begin
          st_next = ST_WAKE;
          wcnt_next = WAKE_LOAD;
          mode_clr = 1'b1;
        end
      end
      ST_WAKE:
      begin
        // oscillator restarting; cpu stays held until count ends
        if (wcnt_reg == '0)
        begin
          st_next = ST_RUN;
        end
        else
        begin
          wcnt_next = wcnt_reg - WCW'(1);
        end
      end
      default:
      begin
        st_next = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_reg <= ST_RUN;
      wcnt_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
      wcnt_reg <= wcnt_next;
    end
  end

  // ***************************************************
  // clock gates
  // ***************************************************
  gate_t gate_reg;
  gate_t gate_next;
  logic clk_live;

  // peripheral clocks live in run and idle only
  assign clk_live = (st_next == ST_RUN) || (st_next == ST_IDLE);

  // gates follow the next state so they line up with it
  always_comb
  begin
    gate_next.cpu_clk_en = (st_next == ST_RUN);
    gate_next.bus_clk_en = (st_next == ST_RUN);
    gate_next.osc_en = (st_next != ST_PDOWN);
    // pll kept through idle; off with the oscillator in power-down
    gate_next.pll_en = clk_reg[CLK_PLL_EN_BIT] && (st_next != ST_PDOWN);
    // connect only once locked, else stay on the oscillator
    gate_next.pll_sel = clk_reg[CLK_PLL_CONN_BIT] && gate_next.pll_en
      && lock_s && clk_live;
    gate_next.pin_hold = (st_next == ST_PDOWN);
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      gate_reg <= '{cpu_clk_en: 1'b1, bus_clk_en: 1'b1, osc_en: 1'b1,
                    pll_en: 1'b0, pll_sel: 1'b0, pin_hold: 1'b0};
    end
    else
    begin
      gate_reg <= gate_next;
    end
  end

  assign gate = gate_reg;

  // ***************************************************
  // peripheral clock divider
  // ***************************************************
  logic div_run;

  // divider keeps ticking in idle so peripherals can interrupt
  assign div_run = clk_live;

  pclk_divider u_div (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .run(div_run),
    .ratio(div_reg),
    .pclk_en(pclk_en)
  );

  // per peripheral gate of the shared enable
  genvar gi;
  generate
    for (gi = 0; gi < N_PERIPH; gi++)
    begin : g_periph
      assign periph_clk_en[gi] = pclk_en && periph_reg[gi];
    end
  endgenerate

  // rtc source; the external 32 kHz path is never gated here,
  // so the rtc keeps counting through power-down
  assign rtc_ext_sel = clk_reg[CLK_RTC_EXT_BIT];
  assign rtc_pclk_en = pclk_en && !clk_reg[CLK_RTC_EXT_BIT];

  // ***************************************************
  // read data
  // ***************************************************
  logic [31:0] rd_reg;
  logic [31:0] rd_next;

  // captured in the setup cycle, shown in the access cycle
  always_comb
  begin
    rd_next = rd_reg;
    if (setup)
    begin
      rd_next = 32'h0000_0000;
      if (addr_is(apb_req.paddr, OFS_MODE))
      begin
        rd_next[1:0] = mode_reg;
      end
      else if (addr_is(apb_req.paddr, OFS_PERIPH))
      begin
        rd_next[N_PERIPH-1:0] = periph_reg;
      end
      else if (addr_is(apb_req.paddr, OFS_DIV))
      begin
        rd_next[1:0] = div_reg;
      end
      else if (addr_is(apb_req.paddr, OFS_CLK))
      begin
        rd_next[2:0] = clk_reg;
      end
      else if (addr_is(apb_req.paddr, OFS_STAT))
      begin
        rd_next[3:0] = st_reg;
        rd_next[STAT_LOCK_BIT] = lock_s;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_reg <= 32'h0000_0000;
    end
    else
    begin
      rd_reg <= rd_next;
    end
  end

  assign prdata = rd_reg;

endmodule

// ### pkg/pwr_clk_pkg.sv
// Purpose: shared constants and types for the power mode and clock controller
// Assumes: 32-bit APB data, one aligned word per register
// Notes: offsets are byte addresses on the APB
package pwr_clk_pkg;

  // ***************************************************
  // register map
  // ***************************************************
  localparam int APB_AW = 8;
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_PERIPH = 8'h04;
  localparam logic [7:0] OFS_DIV = 8'h08;
  localparam logic [7:0] OFS_CLK = 8'h0C;
  localparam logic [7:0] OFS_STAT = 8'h10;

  // ***************************************************
  // field positions and reset values
  // ***************************************************
  localparam int MODE_IDLE_BIT = 0;
  localparam int MODE_PDOWN_BIT = 1;
  localparam int CLK_PLL_EN_BIT = 0;
  localparam int CLK_PLL_CONN_BIT = 1;
  localparam int CLK_RTC_EXT_BIT = 2;
  localparam int STAT_LOCK_BIT = 4;
  localparam logic [1:0] MODE_RESET = 2'h0;
  localparam logic [2:0] CLK_RESET = 3'h0;

  // divider ratio codes; quarter rate is the reset value
  localparam logic [1:0] DIV_QUARTER = 2'h0;
  localparam logic [1:0] DIV_FULL = 2'h1;
  localparam logic [1:0] DIV_HALF = 2'h2;
  localparam logic [1:0] DIV_RESET = DIV_QUARTER;

  // ***************************************************
  // timing and sizes
  // ***************************************************
  localparam int N_PERIPH_DEF = 8;
  localparam int WAKE_CYCLES_DEF = 2048;

  // ***************************************************
  // types
  // ***************************************************
  typedef enum logic [3:0] {
    ST_RUN = 4'h1,
    ST_IDLE = 4'h2,
    ST_PDOWN = 4'h4,
    ST_WAKE = 4'h8
  } pm_state_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic cpu_clk_en;
    logic bus_clk_en;
    logic osc_en;
    logic pll_en;
    logic pll_sel;
    logic pin_hold;
  } gate_t;

  // word address match, used by write and read decode
  function automatic logic addr_is(input logic [7:0] addr, input logic [7:0] ofs);
    addr_is = (addr[7:2] == ofs[7:2]);
  endfunction

endpackage

// ### verification/core_periph_model.sv
// Purpose: cpu core and peripherals beside the controller
// Assumes: bench pulses irq_req and wake_req
// Notes: pll lock after a short settle
`timescale 1ns/1ps
module core_periph_model
  import pwr_clk_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // bench requests
  input wire logic irq_req,
  input wire logic wake_req,
  input wire logic [3:0] irq_dly,
  // controller side
  input wire gate_t gate,
  output logic irq_pending,
  output logic wake_irq,
  output logic pll_lock
);
  logic [3:0] cnt = 4'h0;
  logic [2:0] lock_sh = 3'h0;
  initial {irq_pending, wake_irq, pll_lock} = 3'h0;
  // level irq after a delay, dropped once the core runs
  always @(posedge sys_clk)
  begin
    // a held reset drops any delay still counting
    cnt <= !rst_n ? 4'h0 : irq_req ? irq_dly : (cnt != 4'h0 ? cnt - 4'h1 : 4'h0);
    if (cnt == 4'h1)
      irq_pending <= 1'b1;
    else if (gate.cpu_clk_en)
      irq_pending <= 1'b0;
    if (wake_req)
      wake_irq <= 1'b1;
    else if (gate.osc_en)
      wake_irq <= 1'b0;
    lock_sh <= {lock_sh[1:0], gate.pll_en};
    pll_lock <= &lock_sh;
  end
endmodule

// ### verification/pwr_clk_ctrl_assertions.sv
// Purpose: port checks for pwr_clk_ctrl
// Assumes: one clock, reset active low
// Notes: bound to the top module below
`timescale 1ns/1ps
module pwr_clk_ctrl_chk
  import pwr_clk_pkg::*;
#(
  parameter int N_PERIPH = N_PERIPH_DEF
)
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // wake and gates
  input wire logic irq_pending,
  input wire logic wake_irq,
  input wire gate_t gate,
  input wire logic pclk_en,
  input wire logic [N_PERIPH-1:0] periph_clk_en,
  input wire logic rtc_ext_sel,
  input wire logic rtc_pclk_en
);
  // ***
  // gap counter
  // ***
  logic [3:0] gap_reg;
  logic [3:0] gap_next;
  // cleared while the cpu is gated, as the divider may restart
  always_comb
  begin
    gap_next = (pclk_en || !gate.cpu_clk_en) ? 4'h0 : gap_reg + 4'h1;
  end
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      gap_reg <= 4'h0;
    else
      gap_reg <= gap_next;
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  property p_idle_bus; $fell(gate.cpu_clk_en) |-> !gate.bus_clk_en; endproperty
  a_idle_bus: assert property (p_idle_bus) else $error("bus clock on with cpu gated");
  property p_irq_exit;
    irq_pending && !gate.cpu_clk_en && gate.osc_en |-> ##[1:2] gate.cpu_clk_en;
  endproperty
  a_irq_exit: assert property (p_irq_exit) else $error("idle not left on irq");
  property p_pdown_gate;
    !gate.osc_en |-> !gate.pll_en && !pclk_en && !gate.cpu_clk_en && gate.pin_hold;
  endproperty
  a_pdown_gate: assert property (p_pdown_gate) else $error("clock alive in power-down");
  property p_pdown_keep; !gate.osc_en |-> $stable(rtc_ext_sel); endproperty
  a_pdown_keep: assert property (p_pdown_keep) else $error("state lost in power-down");
  property p_pdown_stay; (!gate.osc_en && !wake_irq)[*3] |=> !gate.osc_en; endproperty
  a_pdown_stay: assert property (p_pdown_stay) else $error("power-down left unasked");
  property p_wake_timer; $rose(gate.osc_en) |-> !gate.cpu_clk_en[*4]; endproperty
  a_wake_timer: assert property (p_wake_timer) else $error("cpu ran before wake timer");
  property p_div_gap; gap_reg <= 4'h5; endproperty
  a_div_gap: assert property (p_div_gap) else $error("peripheral clock too slow");
  property p_rtc_src; rtc_pclk_en == (pclk_en && !rtc_ext_sel); endproperty
  a_rtc_src: assert property (p_rtc_src) else $error("rtc source wrong");
  property p_periph; |periph_clk_en |-> pclk_en; endproperty
  a_periph: assert property (p_periph) else $error("peripheral enable off the grid");
  property p_pll_idle;
    $fell(gate.cpu_clk_en) && gate.osc_en |-> gate.pll_en == $past(gate.pll_en);
  endproperty
  a_pll_idle: assert property (p_pll_idle) else $error("pll changed on idle");
  property p_pll_sel; gate.pll_sel |-> gate.pll_en; endproperty
  a_pll_sel: assert property (p_pll_sel) else $error("pll used while off");

  c_idle: cover property ($fell(gate.cpu_clk_en) && gate.osc_en);
  c_pdown: cover property ($fell(gate.osc_en));
  c_rtc: cover property (rtc_ext_sel && !gate.osc_en);
endmodule

bind pwr_clk_ctrl pwr_clk_ctrl_chk #(.N_PERIPH(N_PERIPH)) chk_i (.sys_clk(sys_clk), .rst_n(rst_n),
  .irq_pending(irq_pending), .wake_irq(wake_irq), .gate(gate), .pclk_en(pclk_en),
  .periph_clk_en(periph_clk_en), .rtc_ext_sel(rtc_ext_sel), .rtc_pclk_en(rtc_pclk_en));

// ### verification/tb.sv
// Purpose: self-checking bench for pwr_clk_ctrl
// Assumes: wake timer shortened to 4
// Notes: zero-wait bus, bounded waits only
`timescale 1ns/1ps
module tb;
  import pwr_clk_pkg::*;
  localparam int WAKE_N = 4;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  apb_req_t apb_req = '0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, irq_pending, wake_irq, pll_lock, pclk_en, rtc_ext_sel, rtc_pclk_en, err;
  gate_t gate;
  logic [7:0] periph_clk_en, m;
  logic irq_req = 1'b0;
  logic wake_req = 1'b0;
  logic [3:0] irq_dly = 4'h1;
  logic [1:0] c, pc;
  logic [7:0] ofs [5] = '{OFS_MODE, OFS_PERIPH, OFS_DIV, OFS_CLK, OFS_STAT};
  logic [31:0] rv [5] = '{32'h0, 32'hFF, 32'h0, 32'h0, 32'h1};
  int fail_count = 0;
  int check_count = 0;
  int seed = 32'h3cfadba8;
  int g, n;

  always #2.5 sys_clk = ~sys_clk;

  pwr_clk_ctrl #(.N_PERIPH(8), .WAKE_CYCLES(WAKE_N)) pwr_clk_ctrl_i (.sys_clk(sys_clk), .rst_n(rst_n),
    .apb_req(apb_req), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq_pending(irq_pending),
    .wake_irq(wake_irq), .pll_lock(pll_lock), .gate(gate), .pclk_en(pclk_en),
    .periph_clk_en(periph_clk_en), .rtc_ext_sel(rtc_ext_sel), .rtc_pclk_en(rtc_pclk_en));
  core_periph_model core_periph_model_i (.sys_clk(sys_clk), .rst_n(rst_n), .irq_req(irq_req),
    .wake_req(wake_req), .irq_dly(irq_dly), .gate(gate), .irq_pending(irq_pending),
    .wake_irq(wake_irq), .pll_lock(pll_lock));

  // ***
  // helpers
  // ***
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic tmo();
    fail_count++;
    $display("ERROR %0t: wait ran out", $time);
    stop_test();
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one bus transfer, held until pready is seen
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge sys_clk);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge sys_clk);
    apb_req.penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1)
    begin
      k++;
      if (k > 50)
        tmo();
      @(posedge sys_clk);
    end
    rd = prdata;
    err = pslverr;
    apb_req <= '0;
  endtask
  // cycles between two peripheral pulses
  task automatic pgap(output int gap);
    int k;
    k = 0;
    @(posedge sys_clk);
    while (pclk_en !== 1'b1)
    begin
      k++;
      if (k > 20)
        tmo();
      @(posedge sys_clk);
    end
    gap = 1;
    @(posedge sys_clk);
    while (pclk_en !== 1'b1 && gap < 20)
    begin
      gap++;
      @(posedge sys_clk);
    end
  endtask
  task automatic wait_cpu(output int k);
    k = 0;
    while (gate.cpu_clk_en !== 1'b1)
    begin
      k++;
      if (k > 200)
        tmo();
      @(posedge sys_clk);
    end
  endtask
  function automatic int exp_gap(input logic [1:0] code);
    return (code == DIV_FULL) ? 1 : (code == DIV_HALF) ? 2 : 4;
  endfunction

  // ***
  // main sequence
  // ***
  initial
  begin
    repeat (5) @(posedge sys_clk);
    chk(gate, 6'h38);
    rst_n <= 1'b1;
    pgap(g);
    chk(g, 4);
    foreach (ofs[i])
    begin
      apb(1'b0, ofs[i], 32'h0);
      chk(rd, rv[i]);
    end
    apb(1'b0, 8'h20, 32'h0);
    chk(err, 1'b1);
    chk(rd, 32'h0);
    $display("reset test done");
    // every code first, then random ones
    pc = DIV_RESET;
    for (int i = 0; i < 8; i++)
    begin
      c = (i < 4) ? i[1:0] : 2'($random(seed));
      apb(1'b1, OFS_DIV, {30'h0, c});
      pgap(g);
      // the swap period is a whole old or a whole new one, never cut
      chk((g == exp_gap(pc)) || (g == exp_gap(c)), 1'b1);
      pgap(g);
      pgap(g);
      chk(g, exp_gap(c));
      pc = c;
    end
    $display("divider test done");
    apb(1'b1, OFS_DIV, {30'h0, DIV_FULL});
    for (int i = 0; i < 4; i++)
    begin
      m = (i == 0) ? 8'h00 : 8'($random(seed));
      apb(1'b1, OFS_PERIPH, {24'h0, m});
      pgap(g);
      chk(periph_clk_en, m);
      chk(rtc_pclk_en, 1'b1);
    end
    $display("peripheral test done");
    apb(1'b1, OFS_CLK, 32'h3);
    repeat (10) @(posedge sys_clk);
    chk(gate.pll_sel, 1'b1);
    apb(1'b1, OFS_MODE, 32'h1);
    repeat (2) @(posedge sys_clk);
    chk(gate, 6'h0E);
    pgap(g);
    chk(g, 1);
    chk(gate.cpu_clk_en, 1'b0);
    irq_dly <= 4'h1 + 4'($random(seed) & 32'h7);
    irq_req <= 1'b1;
    @(posedge sys_clk);
    irq_req <= 1'b0;
    wait_cpu(n);
    // model delay, then one edge to leave idle and one to show it
    chk(n, irq_dly + 2);
    apb(1'b0, OFS_MODE, 32'h0);
    chk(rd, 32'h0);
    $display("idle test done");
    apb(1'b1, OFS_CLK, 32'h7);
    apb(1'b1, OFS_MODE, 32'h2);
    repeat (2) @(posedge sys_clk);
    chk(gate, 6'h01);
    chk(rtc_ext_sel, 1'b1);
    n = 0;
    repeat (20)
    begin
      @(posedge sys_clk);
      n += pclk_en;
    end
    chk(n, 0);
    chk(gate, 6'h01);
    wake_req <= 1'b1;
    @(posedge sys_clk);
    wake_req <= 1'b0;
    wait_cpu(n);
    chk(n >= WAKE_N + 3, 1'b1);
    apb(1'b0, OFS_CLK, 32'h0);
    chk(rd, 32'h7);
    $display("power-down test done");
    stop_test();
  end
endmodule
